// file: verilog/gpl_pkg.sv
package gpl_pkg;

	// ----------------------------------------------------------------
	// Frame length limits
	// ----------------------------------------------------------------
	localparam logic [13:0] GPL_MIN_FRAME_LEN = 14'h003C;
	localparam logic [13:0] GPL_STD_FRAME_LEN = 14'h060C;
	localparam logic [13:0] GPL_JUMBO_FRAME_LEN = 14'h2710;
	localparam logic [13:0] GPL_COMMON_FRAME_LEN = 14'h05EE;

	// ----------------------------------------------------------------
	// Pause frame recognition
	// ----------------------------------------------------------------
	localparam logic [15:0] GPL_MAC_CTRL_TYPE = 16'h8808;
	localparam logic [15:0] GPL_PAUSE_OPCODE = 16'h0001;
	localparam logic [3:0] GPL_TYPE_HI_IDX = 4'hC;
	localparam logic [3:0] GPL_TYPE_LO_IDX = 4'hD;
	localparam logic [3:0] GPL_OPC_HI_IDX = 4'hE;
	localparam logic [3:0] GPL_OPC_LO_IDX = 4'hF;

	// ----------------------------------------------------------------
	// Indicator timing
	// ----------------------------------------------------------------
	localparam int GPL_CLK_HZ = 40000000;
	localparam int GPL_FLASH_MS = 50;
	localparam int GPL_FLASH_CYC = GPL_CLK_HZ / 1000 * GPL_FLASH_MS;

	// ----------------------------------------------------------------
	// Administrative state and indicator colour
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GPL_ADM_IN_SVC = 2'h0,
		GPL_ADM_OUT_SVC = 2'h1,
		GPL_ADM_AUTO_SVC = 2'h2,
		GPL_ADM_MAINT = 2'h3
	} gpl_admin_t;

	typedef enum logic [1:0] {
		GPL_LED_OFF = 2'h0,
		GPL_LED_AMBER = 2'h1,
		GPL_LED_GREEN = 2'h2
	} gpl_led_t;

	// Negotiated flow-control outcome
	typedef struct packed {
		logic done;
		logic partner_aneg;
		logic asym_pause;
	} gpl_neg_t;

	// Byte stream beat
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic crc_err;
		logic [7:0] data;
	} gpl_beat_t;

	// Provisioning settings
	typedef struct packed {
		gpl_admin_t state;
		logic enable;
		logic loopback;
		logic fc_neg_en;
		logic jumbo;
	} gpl_prov_t;

endpackage : gpl_pkg

// file: verilog/gpl_flasher.sv
`timescale 1ns/1ps
module gpl_flasher
	import gpl_pkg::*;
#(
	parameter int FLASH_CYC = GPL_FLASH_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Activity in, blink out
	input wire logic activity,
	output logic blink
);

	logic [31:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic blink_r, blink_nxt;

	// ----------------------------------------------------------------
	// Flash timing
	// ----------------------------------------------------------------
	// Each period with traffic toggles; more frames keep it toggling,
	// so busy ports flash steadily and sparse ports flash sparsely.
	always_comb begin
		cnt_nxt = cnt_r + 32'h1;
		busy_nxt = busy_r | activity;
		blink_nxt = blink_r;
		if (cnt_r >= 32'(FLASH_CYC - 1)) begin
			cnt_nxt = 32'h0;
			busy_nxt = activity;
			blink_nxt = busy_r ? ~blink_r : 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 32'h0;
			busy_r <= 1'b0;
			blink_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			blink_r <= blink_nxt;
		end
	end

	assign blink = blink_r;

endmodule : gpl_flasher

// file: verilog/gpl_port_ctrl.sv
`timescale 1ns/1ps
module gpl_port_ctrl
	import gpl_pkg::*;
#(
	parameter int FLASH_CYC = GPL_FLASH_CYC,
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Provisioning and card status
	input wire gpl_prov_t prov,
	input wire logic sw_operational,
	// Link status
	input wire logic phy_link_up,
	input wire logic phy_signal_ok,
	input wire logic path_fail_local,
	input wire logic path_fail_remote,
	input wire logic circuit_up,
	input wire gpl_neg_t neg_result,
	input wire logic rx_buf_near_full,
	// Received stream from the attached device
	input wire gpl_beat_t rx_in,
	// Forwarded stream toward the transport path
	output gpl_beat_t fwd_out,
	output logic fwd_commit,
	output logic fwd_discard,
	// Laser and path signalling
	output logic laser_tx_en,
	output logic path_fail_to_remote,
	// Flow control
	output logic pause_tx_req,
	output logic fc_active,
	output gpl_neg_t neg_status,
	// Indicators
	output gpl_led_t port_link_traffic_indicator,
	output logic card_failure_indicator,
	output logic card_active_indicator,
	output logic alarm_suppress,
	output logic loopback_permit,
	output logic in_service,
	// Statistics
	output logic [CNT_W-1:0] stat_rx_good,
	output logic [CNT_W-1:0] stat_rx_drop,
	output logic [CNT_W-1:0] stat_rx_pause
);

	// ----------------------------------------------------------------
	// Administrative state
	// ----------------------------------------------------------------
	logic auto_done_r, auto_done_nxt;
	logic pass_ok;

	always_comb begin
		auto_done_nxt = auto_done_r;
		if (prov.state != GPL_ADM_AUTO_SVC)
			auto_done_nxt = 1'b0;
		else if (phy_signal_ok && phy_link_up)
			auto_done_nxt = 1'b1;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			auto_done_r <= 1'b0;
		else
			auto_done_r <= auto_done_nxt;
	end

	always_comb begin
		unique case (prov.state)
			GPL_ADM_IN_SVC: in_service = 1'b1;
			GPL_ADM_OUT_SVC: in_service = 1'b0;
			GPL_ADM_AUTO_SVC: in_service = auto_done_r;
			GPL_ADM_MAINT: in_service = 1'b1;
		endcase
	end

	assign alarm_suppress = (prov.state == GPL_ADM_MAINT);
	assign loopback_permit = (prov.state == GPL_ADM_MAINT);

	// ----------------------------------------------------------------
	// Link integrity
	// ----------------------------------------------------------------
	logic local_fail;
	logic laser_r, laser_nxt;
	logic pfr_r, pfr_nxt;

	// disable or loopback is a failure
	assign local_fail = !prov.enable || prov.loopback || path_fail_local;
	assign pass_ok = in_service && !local_fail && !path_fail_remote &&
		circuit_up && phy_link_up;

	always_comb begin
		laser_nxt = !(local_fail || path_fail_remote);
		pfr_nxt = local_fail;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			laser_r <= 1'b0;
			pfr_r <= 1'b1;
		end else begin
			laser_r <= laser_nxt;
			pfr_r <= pfr_nxt;
		end
	end

	assign laser_tx_en = laser_r;
	assign path_fail_to_remote = pfr_r;

	// ----------------------------------------------------------------
	// Flow control
	// ----------------------------------------------------------------
	gpl_neg_t neg_r, neg_nxt;
	logic pause_r, pause_nxt;

	always_comb begin
		neg_nxt = neg_r;
		if (neg_result.done)
			neg_nxt = neg_result;
	end

	assign fc_active = prov.fc_neg_en && neg_r.done && neg_r.partner_aneg &&
		neg_r.asym_pause;

	always_comb begin
		pause_nxt = fc_active && rx_buf_near_full;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			neg_r <= '0;
			pause_r <= 1'b0;
		end else begin
			neg_r <= neg_nxt;
			pause_r <= pause_nxt;
		end
	end

	assign neg_status = neg_r;
	assign pause_tx_req = pause_r;

	// ----------------------------------------------------------------
	// Frame filter
	// ----------------------------------------------------------------
	// Data is forwarded beat by beat; the verdict comes on the eof beat,
	// so the transport side must hold a frame until commit or discard.
	logic [13:0] len_r, len_nxt;
	logic [15:0] etype_r, etype_nxt;
	logic [15:0] opc_r, opc_nxt;
	logic [13:0] max_len;
	logic [13:0] cur_len;
	logic is_pause;
	logic bad;
	gpl_beat_t fwd_r, fwd_nxt;
	logic commit_r, commit_nxt;
	logic discard_r, discard_nxt;
	logic pause_seen;

	assign max_len = prov.jumbo ? GPL_JUMBO_FRAME_LEN : GPL_STD_FRAME_LEN;
	assign cur_len = rx_in.sof ? 14'h1 : (len_r + 14'h1);

	always_comb begin
		len_nxt = len_r;
		etype_nxt = etype_r;
		opc_nxt = opc_r;
		if (rx_in.valid) begin
			if (len_r != 14'h3FFF || rx_in.sof)
				len_nxt = cur_len;
			if (cur_len == 14'(GPL_TYPE_HI_IDX) + 14'h1)
				etype_nxt[15:8] = rx_in.data;
			if (cur_len == 14'(GPL_TYPE_LO_IDX) + 14'h1)
				etype_nxt[7:0] = rx_in.data;
			if (cur_len == 14'(GPL_OPC_HI_IDX) + 14'h1)
				opc_nxt[15:8] = rx_in.data;
			if (cur_len == 14'(GPL_OPC_LO_IDX) + 14'h1)
				opc_nxt[7:0] = rx_in.data;
		end
	end

	assign is_pause = (etype_r == GPL_MAC_CTRL_TYPE) && (opc_r == GPL_PAUSE_OPCODE);
	assign bad = rx_in.crc_err || (cur_len < GPL_MIN_FRAME_LEN) || (cur_len > max_len);

	always_comb begin
		fwd_nxt = '0;
		commit_nxt = 1'b0;
		discard_nxt = 1'b0;
		pause_seen = 1'b0;
		if (rx_in.valid && pass_ok) begin
			fwd_nxt = rx_in;
			if (rx_in.eof) begin
				pause_seen = is_pause;
				commit_nxt = !bad && !is_pause;
				discard_nxt = bad || is_pause;
			end
		end else if (rx_in.valid && rx_in.eof) begin
			discard_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			len_r <= 14'h0;
			etype_r <= 16'h0000;
			opc_r <= 16'h0000;
			fwd_r <= '0;
			commit_r <= 1'b0;
			discard_r <= 1'b0;
		end else begin
			len_r <= len_nxt;
			etype_r <= etype_nxt;
			opc_r <= opc_nxt;
			fwd_r <= fwd_nxt;
			commit_r <= commit_nxt;
			discard_r <= discard_nxt;
		end
	end

	assign fwd_out = fwd_r;
	assign fwd_commit = commit_r;
	assign fwd_discard = discard_r;

	// ----------------------------------------------------------------
	// Statistics
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] good_r, good_nxt;
	logic [CNT_W-1:0] drop_r, drop_nxt;
	logic [CNT_W-1:0] pcnt_r, pcnt_nxt;

	always_comb begin
		good_nxt = good_r + CNT_W'(commit_nxt);
		drop_nxt = drop_r + CNT_W'(discard_nxt && !pause_seen);
		pcnt_nxt = pcnt_r + CNT_W'(pause_seen);
	end

	// Only reset clears them; prov only decides which counter each frame lands in, never clears
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			good_r <= '0;
			drop_r <= '0;
			pcnt_r <= '0;
		end else begin
			good_r <= good_nxt;
			drop_r <= drop_nxt;
			pcnt_r <= pcnt_nxt;
		end
	end

	assign stat_rx_good = good_r;
	assign stat_rx_drop = drop_r;
	assign stat_rx_pause = pcnt_r;

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	logic blink;
	gpl_led_t led_r, led_nxt;
	logic fail_r, fail_nxt;

	gpl_flasher #(
		.FLASH_CYC(FLASH_CYC)
	) u_flash (
		.mclk(mclk),
		.resetn(resetn),
		.activity(fwd_r.valid),
		.blink(blink)
	);

	always_comb begin
		fail_nxt = !sw_operational;
		if (!phy_link_up)
			led_nxt = GPL_LED_OFF;
		else if (!pass_ok)
			led_nxt = GPL_LED_AMBER;
		else if (blink)
			led_nxt = GPL_LED_OFF;
		else
			led_nxt = GPL_LED_GREEN;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			led_r <= GPL_LED_OFF;
			fail_r <= 1'b1;
		end else begin
			led_r <= led_nxt;
			fail_r <= fail_nxt;
		end
	end

	assign card_failure_indicator = fail_r;
	assign card_active_indicator = !fail_r;
	assign port_link_traffic_indicator = led_r;

endmodule : gpl_port_ctrl

// file: tb/gpl_port_chk.sv
`timescale 1ns/1ps
module gpl_port_chk
	import gpl_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Inputs of the port
	input wire gpl_prov_t prov,
	input wire logic sw_operational,
	input wire logic phy_link_up,
	input wire logic path_fail_remote,
	input wire logic circuit_up,
	input wire gpl_beat_t rx_in,
	// Outputs of the port
	input wire gpl_beat_t fwd_out,
	input wire logic fwd_commit,
	input wire logic fwd_discard,
	input wire logic laser_tx_en,
	input wire logic path_fail_to_remote,
	input wire logic pause_tx_req,
	input wire logic fc_active,
	input wire gpl_led_t port_link_traffic_indicator,
	input wire logic card_failure_indicator,
	input wire logic card_active_indicator,
	input wire logic alarm_suppress,
	input wire logic loopback_permit
);
	// ----------------
	// Port properties
	// ----------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Outputs are registered, so most effects land one edge later
	a_remote_laser: assert property (path_fail_remote |=> !laser_tx_en)
		else $error("laser on during remote failure");
	a_admin_fail: assert property (!prov.enable || prov.loopback |=>
		!laser_tx_en && path_fail_to_remote)
		else $error("disabled or looped port kept laser on");
	a_dark_nolink: assert property (!phy_link_up |=>
		port_link_traffic_indicator == GPL_LED_OFF)
		else $error("indicator lit without link");
	a_amber_block: assert property (phy_link_up && !circuit_up |=>
		port_link_traffic_indicator == GPL_LED_AMBER)
		else $error("indicator not amber while blocked");
	a_oos_block: assert property (prov.state == GPL_ADM_OUT_SVC |=> fwd_out == '0)
		else $error("traffic passed out of service");
	a_crc_drop: assert property (rx_in.valid && rx_in.eof && rx_in.crc_err |=>
		fwd_discard && !fwd_commit)
		else $error("errored frame not discarded");
	a_boot_fail: assert property (!sw_operational |=>
		card_failure_indicator && !card_active_indicator)
		else $error("failure indicator off before operational");
	a_maint_sup: assert property (prov.state == GPL_ADM_MAINT |->
		alarm_suppress && loopback_permit)
		else $error("maintenance not suppressing alarms");
	a_fc_gate: assert property (!fc_active |=> !pause_tx_req)
		else $error("pause requested without flow control");
	// Main scenarios reached
	c_commit: cover property (fwd_commit);
	c_discard: cover property (fwd_discard);
	c_blink: cover property (port_link_traffic_indicator == GPL_LED_GREEN ##1
		port_link_traffic_indicator == GPL_LED_OFF);
endmodule : gpl_port_chk

bind gpl_port_ctrl gpl_port_chk gpl_port_chk_inst (.mclk, .resetn, .prov, .sw_operational,
	.phy_link_up, .path_fail_remote, .circuit_up, .rx_in, .fwd_out, .fwd_commit, .fwd_discard,
	.laser_tx_en, .path_fail_to_remote, .pause_tx_req, .fc_active, .port_link_traffic_indicator,
	.card_failure_indicator, .card_active_indicator, .alarm_suppress, .loopback_permit);

// file: tb/gpl_peer.sv
`timescale 1ns/1ps
module gpl_peer
	import gpl_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Toward the port
	output gpl_beat_t rx_in,
	output gpl_neg_t neg_result
);
	// Idle line until the first frame
	initial begin
		rx_in = '0;
		neg_result = '0;
	end
	// One frame, byte i is i^5A; pause frames carry type and opcode
	task automatic send(int len, bit crc, bit pz);
		logic [31:0] pw;
		logic [7:0] b;
		pw = {GPL_MAC_CTRL_TYPE, GPL_PAUSE_OPCODE};
		for (int i = 0; i < len; i++) begin
			@(negedge mclk);
			b = i[7:0] ^ 8'h5A;
			if (pz && i >= 12 && i <= 15) begin
				b = pw[8*(15-i) +: 8];
			end
			rx_in = '{1'b1, i == 0, i == len - 1, crc && i == len - 1, b};
		end
		// Released line shows no stale byte
		@(negedge mclk);
		rx_in = '{1'b0, 1'b0, 1'b0, 1'b0, ~b};
	endtask : send
	task automatic negotiate(bit aneg, bit asym);
		@(negedge mclk);
		neg_result = '{1'b1, aneg, asym};
	endtask : negotiate
endmodule : gpl_peer

// file: tb/gpl_port_ctrl_tb.sv
`timescale 1ns/1ps
module gpl_port_ctrl_tb;
	import gpl_pkg::*;
	logic mclk, resetn, sw_operational, phy_link_up, phy_signal_ok;
	logic path_fail_local, path_fail_remote, circuit_up, rx_buf_near_full;
	logic fwd_commit, fwd_discard, laser_tx_en, path_fail_to_remote, pause_tx_req, fc_active;
	logic card_failure_indicator, card_active_indicator, alarm_suppress, loopback_permit;
	logic in_service;
	logic [31:0] st_good, st_drop, st_pause;
	gpl_prov_t prov;
	gpl_neg_t neg_result, neg_status;
	gpl_beat_t rx_in, fwd_out;
	gpl_led_t led;
	int failures, checks_done, cyc, bi, dark;
	gpl_peer gpl_peer_inst (.mclk, .rx_in, .neg_result);
	// Short flash period keeps blinking visible in a short run
	gpl_port_ctrl #(.FLASH_CYC(8)) gpl_port_ctrl_inst (.mclk, .resetn, .prov, .sw_operational,
		.phy_link_up, .phy_signal_ok, .path_fail_local, .path_fail_remote, .circuit_up,
		.neg_result, .rx_buf_near_full, .rx_in, .fwd_out, .fwd_commit, .fwd_discard,
		.laser_tx_en, .path_fail_to_remote, .pause_tx_req, .fc_active, .neg_status,
		.port_link_traffic_indicator(led), .card_failure_indicator, .card_active_indicator,
		.alarm_suppress, .loopback_permit, .in_service, .stat_rx_good(st_good),
		.stat_rx_drop(st_drop), .stat_rx_pause(st_pause));
	// 40 MHz clock
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	// Cycle ceiling, blink count and forwarded byte watch
	always @(negedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			end_sim();
		end
		if (led === GPL_LED_OFF) dark++;
		if (fwd_out.valid === 1'b1) begin
			bi = fwd_out.sof ? 0 : bi + 1;
			if (!(bi inside {[12:15]})) chk("fwd byte", bi[7:0] ^ 8'h5A, fwd_out.data);
		end
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	task wait_n(int n);
		repeat (n) @(negedge mclk);
	endtask : wait_n
	task frame(int len, bit crc, bit pz, bit ok);
		gpl_peer_inst.send(len, crc, pz);
		chk("commit,discard", {ok, !ok}, {fwd_commit, fwd_discard});
	endtask : frame
	task t_len;
		frame(59, 0, 0, 0);
		frame(60, 1, 0, 0);
		frame(1548, 0, 0, 1);
		frame(1549, 0, 0, 0);
		prov.jumbo = 1;
		frame(1549, 0, 0, 1);
		frame(10000, 0, 0, 1);
		frame(10001, 0, 0, 0);
		frame(64, 0, 1, 0);
		wait_n(2);
		chk("good", 3, st_good);
		chk("drop", 4, st_drop);
		chk("pause", 1, st_pause);
		chk("laser", 1, laser_tx_en);
	endtask : t_len
	// Each failure cause in turn, then recovery
	task t_laser;
		for (int k = 0; k < 4; k++) begin
			path_fail_local = (k == 0);
			path_fail_remote = (k == 1);
			prov.enable = (k != 2);
			prov.loopback = (k == 3);
			wait_n(2);
			chk("laser,tell", {1'b0, k != 1}, {laser_tx_en, path_fail_to_remote});
			frame(60, 0, 0, 0);
		end
		path_fail_local = 0;
		prov.enable = 1;
		prov.loopback = 0;
		wait_n(2);
		chk("laser", 1, laser_tx_en);
	endtask : t_laser
	task t_led;
		phy_link_up = 0;
		wait_n(2);
		chk("led", GPL_LED_OFF, led);
		phy_link_up = 1;
		circuit_up = 0;
		wait_n(2);
		chk("led", GPL_LED_AMBER, led);
		circuit_up = 1;
		wait_n(2);
		dark = 0;
		wait_n(20);
		chk("led", GPL_LED_GREEN, led);
		chk("idle dark", 0, dark);
		frame(300, 0, 0, 1);
		chk("blink", 1, dark > 0);
	endtask : t_led
	task t_state;
		prov.state = GPL_ADM_OUT_SVC;
		wait_n(1);
		chk("in service", 0, in_service);
		frame(60, 0, 0, 0);
		prov.state = GPL_ADM_MAINT;
		frame(60, 0, 0, 1);
		chk("sup,perm", 2'b11, {alarm_suppress, loopback_permit});
		phy_signal_ok = 0;
		prov.state = GPL_ADM_AUTO_SVC;
		frame(60, 0, 0, 0);
		phy_signal_ok = 1;
		wait_n(2);
		chk("in service", 1, in_service);
		frame(60, 0, 0, 1);
	endtask : t_state
	task t_fc;
		rx_buf_near_full = 1;
		gpl_peer_inst.negotiate(1, 1);
		wait_n(2);
		chk("fc,pause", 2'b11, {fc_active, pause_tx_req});
		chk("neg", 3'b111, neg_status);
		gpl_peer_inst.negotiate(0, 0);
		wait_n(2);
		chk("fc,pause", 2'b00, {fc_active, pause_tx_req});
		chk("neg", 3'b100, neg_status);
		gpl_peer_inst.negotiate(1, 0);
		wait_n(2);
		chk("fc,pause", 2'b00, {fc_active, pause_tx_req});
		gpl_peer_inst.negotiate(1, 1);
		prov.fc_neg_en = 0;
		wait_n(2);
		chk("fc,pause", 2'b00, {fc_active, pause_tx_req});
	endtask : t_fc
	// Totals so far: 6 committed, 10 dropped, 1 pause, all earlier scenarios together
	task t_stats;
		prov = '{GPL_ADM_OUT_SVC, 1'b0, 1'b1, 1'b1, 1'b0};
		wait_n(3);
		chk("good kept", 6, st_good);
		chk("drop kept", 10, st_drop);
		chk("pause kept", 1, st_pause);
	endtask : t_stats
	task end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		{failures, checks_done, cyc, bi, dark} = '0;
		resetn = 0;
		prov = '{GPL_ADM_IN_SVC, 1'b1, 1'b0, 1'b1, 1'b0};
		{sw_operational, path_fail_local, path_fail_remote, rx_buf_near_full} = '0;
		{phy_link_up, phy_signal_ok, circuit_up} = '1;
		wait_n(4);
		chk("laser,fail,tell,led", 5'b01100, {laser_tx_en, card_failure_indicator,
			path_fail_to_remote, led});
		resetn = 1;
		wait_n(2);
		chk("fail,act", 2'b10, {card_failure_indicator, card_active_indicator});
		sw_operational = 1;
		wait_n(2);
		chk("fail,act", 2'b01, {card_failure_indicator, card_active_indicator});
		t_len();
		t_laser();
		t_led();
		t_state();
		t_fc();
		t_stats();
		end_sim();
	end
endmodule : gpl_port_ctrl_tb
